// [include/bop_params.svh]
// Constants of the boot option loader: offsets, field positions, presets and timing
`ifndef BOP_PARAMS_SVH
`define BOP_PARAMS_SVH

// Register byte offsets on the Avalon slave
`define BOP_OFS_OPTIONS    8'h00
`define BOP_OFS_BOOT_STAT  8'h04
`define BOP_OFS_IRQ_STAT   8'h08
`define BOP_OFS_IRQ_MASK   8'h0c
`define BOP_OFS_DIVIDERS   8'h10

// Option byte field positions
`define BOP_BIT_NMI_FUNC   2
`define BOP_BIT_PROG_PORT  1
`define BOP_BIT_LOW_POWER  0
`define BOP_OPT_RESET      8'h00

// Divider presets for the two boot flavours
`define BOP_DIV_LP_FAST    4'h7
`define BOP_DIV_LP_SLOW    4'hf
`define BOP_DIV_NB_FAST    4'h0
`define BOP_DIV_NB_SLOW    4'h1

// Interrupt status bit positions
`define BOP_IRQ_LOADED     0
`define BOP_IRQ_NMI        1
`define BOP_IRQ_PROG       2
`define BOP_IRQ_WIDTH      3

// Select pin settle time before sampling
`define BOP_CLK_MHZ        200
`define BOP_SETTLE_NS      20
`define BOP_SETTLE_CYC     ((`BOP_SETTLE_NS * `BOP_CLK_MHZ + 999) / 1000)

`endif

// [include/bop_pkg.sv]
// Types shared by the boot option loader files
package bop_pkg;

	// Boot sequence states, Gray along wait -> settle -> run
	typedef enum logic [1:0] {
		BOP_ST_WAIT   = 2'b00,
		BOP_ST_SETTLE = 2'b01,
		BOP_ST_RUN    = 2'b11,
		BOP_ST_PROG   = 2'b10
	} bop_state_e;

	// Clock divider presets handed to the clock generator
	typedef struct packed {
		logic [3:0] core_clock_divider;
		logic [3:0] bus_clock_divider;
		logic [3:0] ext_bus_clock_divider;
		logic [3:0] flash_clock_divider;
	} bop_div_s;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} bop_avs_req_s;

	// Avalon-MM answer to the master
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} bop_avs_rsp_s;

endpackage : bop_pkg

// [src/bop_sync.sv]
// Two flip-flop synchroniser for pin inputs
module bop_sync #(
	parameter int         WIDTH   = 1,
	parameter logic [0:0] RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Pin side and synchronised side
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= {WIDTH{RST_VAL}};
			sync_out <= {WIDTH{RST_VAL}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : bop_sync

// [src/bop_irq_ctrl.sv]
// Sticky interrupt status with write-one-to-clear and a mask
module bop_irq_ctrl #(
	parameter int N = 3
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Event pulses from the block
	input  wire logic [N-1:0] event_set,
	// Software access
	input  wire logic         clr_we,
	input  wire logic [N-1:0] clr_data,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] mask_data,
	// State and interrupt line
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);
	logic [N-1:0] clr_bits;

	// Clear only the bits written with one
	assign clr_bits = clr_we ? clr_data : '0;

	// Sticky bits, a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
		end else begin
			status <= (status & ~clr_bits) | event_set;
		end
	end

	// Mask register, one enables the bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= '0;
		end else if (mask_we) begin
			mask <= mask_data;
		end
	end

	// Level interrupt while any unmasked bit is set
	assign irq = |(status & mask);
endmodule : bop_irq_ctrl

// [src/bop_boot_options.sv]
// Boot option loader: option byte capture, boot mode pick, divider presets, NMI gate
//
// How it works
// (RULE_01) Option bit 2 low blocks NMI, pullup stays
// (RULE_02) Option bit 2 high enables NMI pin and interrupt
// (RULE_03) Option bit 1 low ignores select pin, normal boot
// (RULE_04) Option bit 1 high samples select pin for mode
// (RULE_05) Bit 0 low loads dividers 0x7 and 0xF
// (RULE_06) Bit 0 high loads dividers 0x0 and 0x1
// (RULE_07) NMI events raised in every power mode
// (RULE_08) Option byte captured once, frozen until reset
`include "bop_params.svh"

module bop_boot_options (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Avalon-MM slave
	input  wire bop_pkg::bop_avs_req_s avs_req,
	output bop_pkg::bop_avs_rsp_s      avs_rsp,
	// Flash option byte source
	input  wire logic                 opt_valid,
	input  wire logic [7:0]           opt_byte,
	// Shared pin, active low on both functions
	input  wire logic                 prog_port_select_pin_n,
	output logic                      nmi_pin_function,
	output logic                      nmi_pullup_enable,
	// Boot outcome
	output logic                      boot_done,
	output logic                      cpu_run,
	output logic                      prog_mode,
	// Clock divider presets
	output logic                      div_load,
	output bop_pkg::bop_div_s          dividers,
	// Interrupts
	output logic                      nmi_request,
	output logic                      irq
);
	import bop_pkg::*;

	localparam int         SETTLE_CYC = `BOP_SETTLE_CYC;
	localparam logic [7:0] SETTLE_MAX = 8'(SETTLE_CYC);

	// Boot sequence state
	bop_state_e state;
	bop_state_e next_state;
	logic [7:0] settle_cnt;

	// Captured option byte and its fields
	logic [7:0] flash_boot_options;
	logic       nmi_function_option;
	logic       prog_port_option;
	logic       low_power_boot_option;

	// Pin path
	logic pin_sync;
	logic pin_prev;
	logic nmi_int_enable;
	logic nmi_edge;

	// Bus slave
	logic                       ack;
	logic                       req_any;
	logic                       wr_take;
	logic [7:0]                 next_readdata;
	logic [31:0]                readdata;
	logic [`BOP_IRQ_WIDTH-1:0]  irq_events;
	logic [`BOP_IRQ_WIDTH-1:0]  irq_status;
	logic [`BOP_IRQ_WIDTH-1:0]  irq_mask;
	logic                       clr_we;
	logic                       mask_we;
	logic                       enter_run;
	logic                       enter_prog;

	// Word decode shared by the read mux and the write strobes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr[7:2] == ofs[7:2]);
	endfunction : hit

	// Option fields come from the frozen copy only
	assign nmi_function_option   = flash_boot_options[`BOP_BIT_NMI_FUNC];
	assign prog_port_option      = flash_boot_options[`BOP_BIT_PROG_PORT];
	assign low_power_boot_option = flash_boot_options[`BOP_BIT_LOW_POWER];

	// Pin enters through two flops before any logic reads it
	bop_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_pin_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (prog_port_select_pin_n),
		.sync_out (pin_sync)
	);

	// Next state of the boot sequence
	always_comb begin
		next_state = state;
		case (state)
			BOP_ST_WAIT: begin
				if (opt_valid) begin
					next_state = BOP_ST_SETTLE;
				end
			end
			BOP_ST_SETTLE: begin
				if (settle_cnt == 8'h00) begin
					// Select pin only matters when the port option allows it
					if (prog_port_option && !pin_sync) begin // RULE_04
						next_state = BOP_ST_PROG;
					end else begin
						next_state = BOP_ST_RUN; // RULE_03
					end
				end
			end
			BOP_ST_RUN: begin
				next_state = BOP_ST_RUN;
			end
			BOP_ST_PROG: begin
				next_state = BOP_ST_PROG;
			end
			default: begin
				next_state = BOP_ST_WAIT;
			end
		endcase
	end

	// Leaving the settle state is the reset exit
	assign enter_run  = (state == BOP_ST_SETTLE) && (next_state == BOP_ST_RUN);
	assign enter_prog = (state == BOP_ST_SETTLE) && (next_state == BOP_ST_PROG);

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= BOP_ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// Settle counter lets the pin pass the synchroniser before sampling
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt <= SETTLE_MAX;
		end else if (state == BOP_ST_SETTLE && settle_cnt != 8'h00) begin
			settle_cnt <= settle_cnt - 8'h01;
		end
	end

	// Option byte taken once per reset, never written by software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_boot_options <= `BOP_OPT_RESET;
		end else if (state == BOP_ST_WAIT && opt_valid) begin
			flash_boot_options <= opt_byte; // RULE_08
		end
	end

	// Boot outcome flags, held until the next reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_done <= 1'b0;
			cpu_run   <= 1'b0;
			prog_mode <= 1'b0;
		end else if (enter_run || enter_prog) begin
			boot_done <= 1'b1;
			cpu_run   <= enter_run; // RULE_03
			prog_mode <= enter_prog; // RULE_04
		end
	end

	// Divider presets loaded at reset exit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dividers.core_clock_divider    <= `BOP_DIV_LP_FAST;
			dividers.bus_clock_divider     <= `BOP_DIV_LP_FAST;
			dividers.ext_bus_clock_divider <= `BOP_DIV_LP_SLOW;
			dividers.flash_clock_divider   <= `BOP_DIV_LP_SLOW;
		end else if (enter_run || enter_prog) begin
			if (low_power_boot_option) begin
				dividers.core_clock_divider    <= `BOP_DIV_NB_FAST; // RULE_06
				dividers.bus_clock_divider     <= `BOP_DIV_NB_FAST; // RULE_06
				dividers.ext_bus_clock_divider <= `BOP_DIV_NB_SLOW; // RULE_06
				dividers.flash_clock_divider   <= `BOP_DIV_NB_SLOW; // RULE_06
			end else begin
				dividers.core_clock_divider    <= `BOP_DIV_LP_FAST; // RULE_05
				dividers.bus_clock_divider     <= `BOP_DIV_LP_FAST; // RULE_05
				dividers.ext_bus_clock_divider <= `BOP_DIV_LP_SLOW; // RULE_05
				dividers.flash_clock_divider   <= `BOP_DIV_LP_SLOW; // RULE_05
			end
		end
	end

	// One-cycle strobe telling the clock generator to take the presets
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_load <= 1'b0;
		end else begin
			div_load <= enter_run || enter_prog;
		end
	end

	// Pin defaults to the interrupt function with pullup either way
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_pin_function  <= 1'b1;
			nmi_pullup_enable <= 1'b1;
		end else begin
			nmi_pin_function  <= 1'b1; // RULE_01
			nmi_pullup_enable <= 1'b1; // RULE_01
		end
	end

	// NMI enable follows the option bit, off until boot completes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_int_enable <= 1'b0;
		end else if (enter_run || enter_prog) begin
			nmi_int_enable <= nmi_function_option; // RULE_01 RULE_02
		end
	end

	// Previous synchronised pin level for the edge detect
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= pin_sync;
		end
	end

	// Falling edge of the pin, no power mode term gates it
	assign nmi_edge = nmi_int_enable && pin_prev && !pin_sync; // RULE_07

	// Registered NMI request pulse to the core
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_request <= 1'b0;
		end else begin
			nmi_request <= nmi_edge; // RULE_02 RULE_07
		end
	end

	// Events that set sticky status bits
	always_comb begin
		irq_events                  = '0;
		irq_events[`BOP_IRQ_LOADED] = enter_run || enter_prog;
		irq_events[`BOP_IRQ_NMI]    = nmi_edge; // RULE_07
		irq_events[`BOP_IRQ_PROG]   = enter_prog;
	end

	// Bus write strobes, taken at the edge where waitrequest is low
	assign req_any = avs_req.read || avs_req.write;
	assign wr_take = avs_req.write && ack && avs_req.byteenable[0];
	assign clr_we  = wr_take && hit(avs_req.address, `BOP_OFS_IRQ_STAT);
	assign mask_we = wr_take && hit(avs_req.address, `BOP_OFS_IRQ_MASK);

	// Status, mask and interrupt line
	bop_irq_ctrl #(
		.N (`BOP_IRQ_WIDTH)
	) u_irq (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.event_set (irq_events),
		.clr_we    (clr_we),
		.clr_data  (avs_req.writedata[`BOP_IRQ_WIDTH-1:0]),
		.mask_we   (mask_we),
		.mask_data (avs_req.writedata[`BOP_IRQ_WIDTH-1:0]),
		.status    (irq_status),
		.mask      (irq_mask),
		.irq       (irq)
	);

	// One wait state: first cycle of a request is held off
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= req_any && !ack;
		end
	end

	// Read mux, unmapped words read as zero
	always_comb begin
		next_readdata = 8'h00;
		if (hit(avs_req.address, `BOP_OFS_OPTIONS)) begin
			next_readdata = flash_boot_options;
		end else if (hit(avs_req.address, `BOP_OFS_BOOT_STAT)) begin
			next_readdata = {3'h0, prog_mode, cpu_run, boot_done, state};
		end else if (hit(avs_req.address, `BOP_OFS_IRQ_STAT)) begin
			next_readdata = {5'h00, irq_status};
		end else if (hit(avs_req.address, `BOP_OFS_IRQ_MASK)) begin
			next_readdata = {5'h00, irq_mask};
		end else if (hit(avs_req.address, `BOP_OFS_DIVIDERS)) begin
			next_readdata = {dividers.core_clock_divider, dividers.bus_clock_divider};
		end
	end

	// Read data registered in the held-off cycle, valid with waitrequest low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (avs_req.read && !ack) begin
			if (hit(avs_req.address, `BOP_OFS_DIVIDERS)) begin
				readdata <= {16'h0000, dividers};
			end else begin
				readdata <= {24'h00_0000, next_readdata};
			end
		end
	end

	// Answer to the master
	assign avs_rsp.readdata    = readdata;
	assign avs_rsp.waitrequest = req_any && !ack;
endmodule : bop_boot_options

// [testbench/bop_boot_options_props.sv]
// Port assertions for the boot option loader
module bop_boot_options_chk (
	// Clock and reset
	input wire logic                  ref_clk,
	input wire logic                  rst_n,
	// Register bus
	input wire bop_pkg::bop_avs_req_s avs_req,
	input wire bop_pkg::bop_avs_rsp_s avs_rsp,
	// Option source and shared pin
	input wire logic                  opt_valid,
	input wire logic [7:0]            opt_byte,
	input wire logic                  prog_port_select_pin_n,
	// Boot outcome
	input wire logic                  nmi_pin_function,
	input wire logic                  nmi_pullup_enable,
	input wire logic                  boot_done,
	input wire logic                  cpu_run,
	input wire logic                  prog_mode,
	input wire logic                  div_load,
	input wire bop_pkg::bop_div_s     dividers,
	input wire logic                  nmi_request,
	input wire logic                  irq
);
	timeunit 1ns;
	timeprecision 100ps;
	import bop_pkg::*;
	logic       cap_done;
	logic [7:0] cap_byte;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// First option byte offered after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_done <= 1'b0;
			cap_byte <= 8'h00;
		end else if (opt_valid && !cap_done) begin
			cap_done <= 1'b1;
			cap_byte <= opt_byte;
		end
	end
	// Capture, settle, boot exit, divider load pulse
	sequence s_capture;
		opt_valid && !cap_done;
	endsequence
	sequence s_boot_walk;
		!boot_done [*6] ##1 (boot_done && div_load) ##1 !div_load;
	endsequence
	chk_boot_walk: assert property (s_capture |-> s_boot_walk)
		else $error("boot exit sequence timing wrong");
	chk_div_slow: assert property ($rose(boot_done) && !cap_byte[0] |-> dividers == 16'h77ff)
		else $error("low power divider preset wrong");
	chk_div_fast: assert property ($rose(boot_done) && cap_byte[0] |-> dividers == 16'h0011)
		else $error("normal divider preset wrong");
	chk_prog_ignore: assert property (boot_done && !cap_byte[1] |-> cpu_run && !prog_mode)
		else $error("select pin not ignored");
	chk_prog_pick: assert property ($rose(boot_done) && cap_byte[1] |->
		prog_mode == !prog_port_select_pin_n && cpu_run == prog_port_select_pin_n)
		else $error("boot mode does not follow select pin");
	chk_nmi_block: assert property (cap_done && !cap_byte[2] |-> !nmi_request)
		else $error("nmi raised while disabled");
	chk_nmi_fire: assert property (boot_done && cap_byte[2] && $fell(prog_port_select_pin_n)
		|-> ##[1:5] nmi_request)
		else $error("nmi not raised on pin assertion");
	chk_pin_func: assert property (nmi_pin_function && nmi_pullup_enable)
		else $error("nmi pin function or pullup off");
	chk_opt_read: assert property (cap_done && avs_req.read && avs_req.address == 8'h00
		&& !avs_rsp.waitrequest |-> avs_rsp.readdata[2:0] == cap_byte[2:0])
		else $error("option readback differs from captured byte");
	chk_flags_hold: assert property (boot_done |=> boot_done && $stable(dividers)
		&& $stable(cpu_run) && $stable(prog_mode))
		else $error("boot results changed before reset");
endmodule : bop_boot_options_chk

bind bop_boot_options bop_boot_options_chk bop_boot_options_chk_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
	.opt_valid(opt_valid), .opt_byte(opt_byte), .prog_port_select_pin_n(prog_port_select_pin_n),
	.nmi_pin_function(nmi_pin_function), .nmi_pullup_enable(nmi_pullup_enable),
	.boot_done(boot_done), .cpu_run(cpu_run), .prog_mode(prog_mode), .div_load(div_load),
	.dividers(dividers), .nmi_request(nmi_request), .irq(irq));

// [testbench/bop_flash_model.sv]
// Flash option byte source with adjustable latency
module bop_flash_model (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Byte to offer and cycles before offering
	input  wire logic [7:0] opt_val,
	input  wire logic [3:0] lat,
	// Option byte handshake
	output logic            opt_valid,
	output logic [7:0]      opt_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] cnt;
	logic       offer;
	// Cycles since reset exit, saturating
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5'h00;
		end else if (cnt != 5'h1f) begin
			cnt <= cnt + 5'h01;
		end
	end
	// Three cycle offer, then a stale retry with inverted data
	assign offer     = ({1'b0, lat} <= cnt) && (cnt < {1'b0, lat} + 5'h03);
	assign opt_valid = offer || (cnt == 5'h1f);
	assign opt_byte  = offer ? opt_val : ~opt_val;
endmodule : bop_flash_model

// [testbench/tb.sv]
// Self-checking bench for the boot option loader
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bop_pkg::*;
	logic         ref_clk;
	logic         rst_n;
	logic         pin_n;
	logic         opt_valid;
	logic [7:0]   opt_byte;
	logic [7:0]   opt_val;
	logic [3:0]   lat;
	bop_avs_req_s avs_req;
	bop_avs_rsp_s avs_rsp;
	logic         nmi_func;
	logic         nmi_pull;
	logic         boot_done;
	logic         cpu_run;
	logic         prog_mode;
	logic         div_load;
	bop_div_s     dividers;
	logic         nmi_request;
	logic         irq;
	int           error_cnt = 0;
	int           n_compared = 0;
	int           nmi_cnt;

	bop_boot_options bop_boot_options_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_req(avs_req), .avs_rsp(avs_rsp), .opt_valid(opt_valid), .opt_byte(opt_byte),
		.prog_port_select_pin_n(pin_n), .nmi_pin_function(nmi_func),
		.nmi_pullup_enable(nmi_pull), .boot_done(boot_done), .cpu_run(cpu_run),
		.prog_mode(prog_mode), .div_load(div_load), .dividers(dividers),
		.nmi_request(nmi_request), .irq(irq));
	bop_flash_model bop_flash_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .opt_val(opt_val),
		.lat(lat), .opt_valid(opt_valid), .opt_byte(opt_byte));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Count NMI pulses since the last reset
	always @(negedge ref_clk) begin
		nmi_cnt <= rst_n ? nmi_cnt + int'(nmi_request === 1'b1) : 0;
	end
	// Counts and verdict
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	// Compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One Avalon transfer, entered just after a rising edge
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rdv);
		int n;
		n = 0;
		avs_req <= '{a, !wr, wr, wd, 4'hf};
		// Waitrequest and read data are taken at the rising edge only
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_rsp.waitrequest !== 1'b0);
		rdv = avs_rsp.readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		// One wait state: answer at the second edge
		chk("bus edges", 32'h2, 32'(n));
		// Idle edge so the next request never meets this release
		@(posedge ref_clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what,
		input logic [31:0] msk = 32'hffffffff);
		logic [31:0] v;
		bus(a, 1'b0, 32'h0, v);
		chk(what, exp, v & msk);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(a, 1'b1, d, v);
	endtask : wr
	// Settled interrupt level, back on a rising edge
	task automatic irq_is(input logic exp);
		@(negedge ref_clk);
		chk("irq", {31'h0, exp}, {31'h0, irq});
		@(posedge ref_clk);
	endtask : irq_is
	// Reset with an option byte and pin level, then wait for boot exit
	task automatic boot(input logic [7:0] o, input logic p);
		int n;
		rst_n <= 1'b0;
		opt_val <= o;
		lat <= {2'b00, o[0], o[2]};
		pin_n <= p;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (boot_done !== 1'b1 && n < 50);
		chk("boot_done", 32'h1, {31'h0, boot_done});
		repeat (3) @(posedge ref_clk);
	endtask : boot

	// Every value of option bits 2:0 with the select pin high and low
	initial begin
		logic [7:0]  ob;
		logic        pr;
		logic [15:0] dv;
		rst_n = 1'b0;
		pin_n = 1'b1;
		opt_val = 8'h00;
		lat = 4'h0;
		avs_req = '0;
		for (int o = 0; o < 8; o++) begin
			for (int p = 0; p < 2; p++) begin
				ob = {5'b10101, o[2:0]};
				pr = ob[1] & ~p[0];
				dv = ob[0] ? 16'h0011 : 16'h77ff;
				boot(ob, p[0]);
				@(negedge ref_clk);
				chk("cpu_run", {31'h0, !pr}, {31'h0, cpu_run});
				chk("prog_mode", {31'h0, pr}, {31'h0, prog_mode});
				chk("dividers", {16'h0, dv}, {16'h0, dividers});
				chk("nmi pin", 32'h3, {30'h0, nmi_func, nmi_pull});
				@(posedge ref_clk);
				pin_n <= 1'b1;
				repeat (4) @(posedge ref_clk);
				pin_n <= 1'b0;
				repeat (4) @(posedge ref_clk);
				pin_n <= 1'b1;
				repeat (6) @(posedge ref_clk);
				chk("nmi_request", {31'h0, ob[2]}, nmi_cnt);
				rd(8'h00, {29'h0, ob[2:0]}, "options", 32'h7);
				wr(8'h00, {24'h0, ~ob});
				rd(8'h00, {29'h0, ob[2:0]}, "options kept", 32'h7);
				rd(8'h10, {16'h0, dv}, "divider reg");
				rd(8'h04, {27'h0, pr, !pr, 1'b1, 1'b1, !pr}, "boot status");
				rd(8'h08, {29'h0, pr, ob[2], 1'b1}, "irq status");
				irq_is(1'b0);
				wr(8'h0c, 32'h7);
				irq_is(1'b1);
				wr(8'h08, 32'h7);
				rd(8'h08, 32'h0, "irq cleared");
				irq_is(1'b0);
				wr(8'h0c, 32'h0);
				rd(8'h20, 32'h0, "unmapped");
				$display("test options %h pin %0d finished", ob, p);
			end
		end
		end_of_test;
	end
	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		end_of_test;
	end
endmodule : tb
